/* core/sea_defs.vh */
// Constants for the two-wire serial EEPROM access slave
`ifndef SEA_DEFS_VH
`define SEA_DEFS_VH

// ----------------------------------------------------------------------------
// Array geometry
// ----------------------------------------------------------------------------
`define SEA_ADDR_W          12
`define SEA_DATA_W          8
`define SEA_PAGE_W          5
`define SEA_PAGE_BYTES      32
`define SEA_PROT_BIT        11

// ----------------------------------------------------------------------------
// Slave address and address byte fields
// ----------------------------------------------------------------------------
`define SEA_DEV_TYPE        4'hA
`define SEA_SA_TYPE_RNG     7:4
`define SEA_SA_CS_RNG       3:1
`define SEA_SA_RW_BIT       0
`define SEA_AH_USED_RNG     3:0

// ----------------------------------------------------------------------------
// Bit slot counts within one byte frame
// ----------------------------------------------------------------------------
`define SEA_BIT_DATA        4'h8
`define SEA_BIT_ACK         4'h9

// ----------------------------------------------------------------------------
// Timing: internal_write_time, rounded up to whole core clocks
// ----------------------------------------------------------------------------
`define SEA_CLK_PERIOD_NS   10
`define SEA_WR_TIME_NS      10000
`define SEA_WR_CYCLES       ((`SEA_WR_TIME_NS + `SEA_CLK_PERIOD_NS - 1) / `SEA_CLK_PERIOD_NS)

`endif

/* core/sea_mem_array.v */
// Flip-flop storage array of the serial EEPROM
`timescale 1ns/100ps
`default_nettype none

module sea_mem_array #(
	parameter AW = 12,
	parameter DW = 8
) (
	// Clock and enable
	input  wire          i_clk,
	input  wire          i_ce,
	// Write port
	input  wire          i_we,
	input  wire [AW-1:0] i_waddr,
	input  wire [DW-1:0] i_wdata,
	// Read port
	input  wire [AW-1:0] i_raddr,
	output wire [DW-1:0] o_rdata
);

	reg [DW-1:0] mem_q [0:(1<<AW)-1];

	// ------------------------------------------------------------------------
	// Storage
	// ------------------------------------------------------------------------
	always @(posedge i_clk) begin
		if (i_ce && i_we) begin
			mem_q[i_waddr] <= i_wdata;
		end
	end

	assign o_rdata = mem_q[i_raddr];

endmodule
`default_nettype wire

/* core/sea_eeprom_slave.v */
// Two-wire bus slave logic of a 4096 x 8 serial EEPROM
`timescale 1ns/100ps
`default_nettype none
`include "sea_defs.vh"

module sea_eeprom_slave #(
	parameter LOCKOUT_EN = 1,
	parameter WR_CYCLES  = `SEA_WR_CYCLES,
	parameter WR_CNT_W   = 24
) (
	// Clock, reset and enable
	input  wire        i_core_clk,
	input  wire        i_sys_rst,
	input  wire        i_ce,
	// Two-wire bus pins
	input  wire        i_scl,
	input  wire        i_sda,
	output wire        o_sda_out,
	output wire        o_sda_oe,
	// Straps and supply monitor
	input  wire [2:0]  i_chip_select_pins,
	input  wire        i_wp,
	input  wire        i_vcc_low,
	// Status
	output wire        o_busy
);

	// ------------------------------------------------------------------------
	// Local constants
	// ------------------------------------------------------------------------
	localparam AW = `SEA_ADDR_W;
	localparam DW = `SEA_DATA_W;
	localparam PW = `SEA_PAGE_W;
	localparam NB = `SEA_PAGE_BYTES;

	localparam [5:0] ST_IDLE = 6'h01;
	localparam [5:0] ST_DEV  = 6'h02;
	localparam [5:0] ST_ADH  = 6'h04;
	localparam [5:0] ST_ADL  = 6'h08;
	localparam [5:0] ST_WR   = 6'h10;
	localparam [5:0] ST_RD   = 6'h20;

	localparam integer        WR_LAST_I = WR_CYCLES - 1;
	localparam [WR_CNT_W-1:0] WR_LAST   = WR_LAST_I[WR_CNT_W-1:0];

	// ------------------------------------------------------------------------
	// Functions
	// ------------------------------------------------------------------------
	function [AW-1:0] next_in_page;
		input [AW-1:0] a;
		begin
			next_in_page = {a[AW-1:PW], a[PW-1:0] + {{(PW-1){1'b0}}, 1'b1}};
		end
	endfunction

	function [AW-1:0] next_in_array;
		input [AW-1:0] a;
		begin
			next_in_array = a + {{(AW-1){1'b0}}, 1'b1};
		end
	endfunction

	// ------------------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------------------
	reg            scl_m_q;
	reg            scl_s_q;
	reg            scl_p_q;
	reg            sda_m_q;
	reg            sda_s_q;
	reg            sda_p_q;
	reg            wp_m_q;
	reg            wp_s_q;
	reg            lo_m_q;
	reg            lo_s_q;
	reg  [2:0]     cs_m_q;
	reg  [2:0]     cs_s_q;

	reg  [5:0]     state_q;
	reg  [5:0]     nxt_q;
	reg  [3:0]     bit_q;
	reg  [DW-1:0]  rx_q;
	reg  [DW-1:0]  tx_q;
	reg            drv_q;
	reg  [AW-1:0]  addr_q;
	reg  [3:0]     hi_q;
	reg            first_q;
	reg            pend_q;
	reg            busy_q;
	reg  [WR_CNT_W-1:0] wcnt_q;
	reg  [NB-1:0]  vld_q;
	reg  [DW-1:0]  buf_q [0:NB-1];

	wire           scl_rise;
	wire           scl_fall;
	wire           start_det;
	wire           stop_det;
	wire           sa_match;
	wire           wr_locked;
	wire           mem_we;
	wire [PW-1:0]  prog_idx;
	wire [DW-1:0]  rdata;

	// ------------------------------------------------------------------------
	// Pin synchronisers and bus condition detection
	// ------------------------------------------------------------------------
	always @(posedge i_core_clk) begin
		if (i_sys_rst) begin
			scl_m_q <= 1'b1;
			scl_s_q <= 1'b1;
			scl_p_q <= 1'b1;
			sda_m_q <= 1'b1;
			sda_s_q <= 1'b1;
			sda_p_q <= 1'b1;
			wp_m_q  <= 1'b0;
			wp_s_q  <= 1'b0;
			lo_m_q  <= 1'b0;
			lo_s_q  <= 1'b0;
			cs_m_q  <= 3'h0;
			cs_s_q  <= 3'h0;
		end else if (i_ce) begin
			scl_m_q <= i_scl;
			scl_s_q <= scl_m_q;
			scl_p_q <= scl_s_q;
			sda_m_q <= i_sda;
			sda_s_q <= sda_m_q;
			sda_p_q <= sda_s_q;
			wp_m_q  <= i_wp;
			wp_s_q  <= wp_m_q;
			lo_m_q  <= i_vcc_low;
			lo_s_q  <= lo_m_q;
			cs_m_q  <= i_chip_select_pins;
			cs_s_q  <= cs_m_q;
		end
	end

	assign scl_rise  = scl_s_q & ~scl_p_q;
	assign scl_fall  = ~scl_s_q & scl_p_q;
	assign start_det = scl_s_q & scl_p_q & sda_p_q & ~sda_s_q;
	assign stop_det  = scl_s_q & scl_p_q & ~sda_p_q & sda_s_q;

	// Slave address compare against type and chip select straps
	assign sa_match = (rx_q[`SEA_SA_TYPE_RNG] == `SEA_DEV_TYPE) &&
	                  (rx_q[`SEA_SA_CS_RNG] == cs_s_q);

	// Upper half protected only while the pin is high; supply lockout blocks all
	assign wr_locked = (wp_s_q & addr_q[`SEA_PROT_BIT]) |
	                   ((LOCKOUT_EN != 0) & lo_s_q);

	// ------------------------------------------------------------------------
	// Array programming from the page buffer
	// ------------------------------------------------------------------------
	assign prog_idx = wcnt_q[PW-1:0];
	assign mem_we   = busy_q && (wcnt_q < NB) && vld_q[prog_idx];

	sea_mem_array #(
		.AW (AW),
		.DW (DW)
	) u_mem (
		.i_clk   (i_core_clk),
		.i_ce    (i_ce),
		.i_we    (mem_we),
		.i_waddr ({addr_q[AW-1:PW], prog_idx}),
		.i_wdata (buf_q[prog_idx]),
		.i_raddr (addr_q),
		.o_rdata (rdata)
	);

	// ------------------------------------------------------------------------
	// Page buffer storage
	// ------------------------------------------------------------------------
	always @(posedge i_core_clk) begin
		if (i_ce && !busy_q && scl_fall && state_q == ST_WR &&
		    bit_q == `SEA_BIT_DATA && (!first_q || !wr_locked)) begin
			buf_q[addr_q[PW-1:0]] <= rx_q;
		end
	end

	// ------------------------------------------------------------------------
	// Protocol engine
	// ------------------------------------------------------------------------
	always @(posedge i_core_clk) begin
		if (i_sys_rst) begin
			state_q <= ST_IDLE;
			nxt_q   <= ST_IDLE;
			bit_q   <= 4'h0;
			rx_q    <= 8'h00;
			tx_q    <= 8'h00;
			drv_q   <= 1'b0;
			addr_q  <= 12'h000;
			hi_q    <= 4'h0;
			first_q <= 1'b0;
			pend_q  <= 1'b0;
			busy_q  <= 1'b0;
			wcnt_q  <= {WR_CNT_W{1'b0}};
			vld_q   <= {NB{1'b0}};
		end else if (i_ce) begin
			if (busy_q) begin
				// Bus is not watched at all during the write cycle
				state_q <= ST_IDLE;
				drv_q   <= 1'b0;
				bit_q   <= 4'h0;
				wcnt_q  <= wcnt_q + {{(WR_CNT_W-1){1'b0}}, 1'b1};
				if (wcnt_q == WR_LAST) begin
					busy_q <= 1'b0;
					vld_q  <= {NB{1'b0}};
				end
			end else if (start_det) begin
				// Start or repeated start abandons any unfinished write
				state_q <= ST_DEV;
				bit_q   <= 4'h0;
				drv_q   <= 1'b0;
				pend_q  <= 1'b0;
			end else if (stop_det) begin
				state_q <= ST_IDLE;
				bit_q   <= 4'h0;
				drv_q   <= 1'b0;
				if (pend_q) begin
					busy_q <= 1'b1;
					wcnt_q <= {WR_CNT_W{1'b0}};
					pend_q <= 1'b0;
				end
			end else if (state_q == ST_RD) begin
				// Transmit path
				if (scl_rise) begin
					if (bit_q < `SEA_BIT_DATA) begin
						bit_q <= bit_q + 4'h1;
					end else if (bit_q == `SEA_BIT_DATA) begin
						if (!sda_s_q) begin
							bit_q <= `SEA_BIT_ACK;
						end else begin
							state_q <= ST_IDLE;
							bit_q   <= 4'h0;
						end
					end
				end else if (scl_fall) begin
					if (bit_q == `SEA_BIT_DATA) begin
						drv_q  <= 1'b0;
						addr_q <= next_in_array(addr_q);
					end else if (bit_q == `SEA_BIT_ACK) begin
						tx_q  <= {rdata[DW-2:0], 1'b0};
						drv_q <= ~rdata[DW-1];
						bit_q <= 4'h0;
					end else if (bit_q != 4'h0) begin
						drv_q <= ~tx_q[DW-1];
						tx_q  <= {tx_q[DW-2:0], 1'b0};
					end
				end
			end else if (state_q != ST_IDLE) begin
				// Receive path for slave address, address and data bytes
				if (scl_rise) begin
					if (bit_q < `SEA_BIT_DATA) begin
						rx_q  <= {rx_q[DW-2:0], sda_s_q};
						bit_q <= bit_q + 4'h1;
					end else if (bit_q == `SEA_BIT_DATA) begin
						bit_q <= `SEA_BIT_ACK;
					end
				end else if (scl_fall) begin
					if (bit_q == `SEA_BIT_ACK) begin
						drv_q   <= 1'b0;
						bit_q   <= 4'h0;
						state_q <= nxt_q;
						if (nxt_q == ST_RD) begin
							// First read byte goes out right after the acknowledge
							tx_q  <= {rdata[DW-2:0], 1'b0};
							drv_q <= ~rdata[DW-1];
						end
					end else if (bit_q == `SEA_BIT_DATA) begin
						case (state_q)
							ST_DEV: begin
								if (sa_match) begin
									drv_q <= 1'b1;
									if (rx_q[`SEA_SA_RW_BIT]) begin
										nxt_q <= ST_RD;
									end else begin
										nxt_q <= ST_ADH;
									end
								end else begin
									state_q <= ST_IDLE;
									bit_q   <= 4'h0;
								end
							end
							ST_ADH: begin
								hi_q  <= rx_q[`SEA_AH_USED_RNG];
								drv_q <= 1'b1;
								nxt_q <= ST_ADL;
							end
							ST_ADL: begin
								addr_q  <= {hi_q, rx_q};
								drv_q   <= 1'b1;
								first_q <= 1'b1;
								vld_q   <= {NB{1'b0}};
								nxt_q   <= ST_WR;
							end
							ST_WR: begin
								if (first_q && wr_locked) begin
									// No acknowledge and nothing left pending
									state_q <= ST_IDLE;
									bit_q   <= 4'h0;
								end else begin
									drv_q   <= 1'b1;
									first_q <= 1'b0;
									pend_q  <= 1'b1;
									vld_q[addr_q[PW-1:0]] <= 1'b1;
									addr_q  <= next_in_page(addr_q);
									nxt_q   <= ST_WR;
								end
							end
							default: begin
								state_q <= ST_IDLE;
								bit_q   <= 4'h0;
							end
						endcase
					end
				end
			end
		end
	end

	// ------------------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------------------
	assign o_sda_out = 1'b0;
	assign o_sda_oe  = drv_q;
	assign o_busy    = busy_q;

endmodule
`default_nettype wire

/* dv/sea_eeprom_slave_monitor.sv */
// Pin-level assertions for the EEPROM slave
`timescale 1ns/100ps
`default_nettype none
module sea_eeprom_slave_monitor #(
	parameter WR_CYCLES = 300
) (
	// Clock, reset and bus pins
	input wire logic i_core_clk,
	input wire logic i_sys_rst,
	input wire logic i_scl,
	input wire logic i_sda,
	// Device outputs
	input wire logic o_sda_oe,
	input wire logic o_busy
);
	logic [23:0] bcnt_q;
	logic [3:0]  scnt_q;
	logic        sda_q;
	logic        sel_q;
	wire         stp = i_scl && i_sda && !sda_q;
	wire         sta = i_scl && !i_sda && sda_q;
	always @(posedge i_core_clk) begin
		sda_q <= i_sda;
		bcnt_q <= o_busy ? bcnt_q + 24'h1 : 24'h0;
		if (i_sys_rst) begin
			scnt_q <= 4'hF;
			sel_q <= 1'h0;
		end else begin
			scnt_q <= stp ? 4'h0 : scnt_q + {3'h0, scnt_q != 4'hF};
			sel_q <= sta | (sel_q & !stp);
		end
	end
	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (i_sys_rst);
	property p_busy_len; $fell(o_busy) |-> bcnt_q == WR_CYCLES; endproperty
	a_busy_len: assert property (p_busy_len) else $error("busy length");
	property p_busy_max; o_busy |-> bcnt_q < WR_CYCLES; endproperty
	a_busy_max: assert property (p_busy_max) else $error("busy too long");
	property p_busy_stop; $rose(o_busy) |-> scnt_q < 4'hC; endproperty
	a_busy_stop: assert property (p_busy_stop) else $error("busy without stop");
	property p_busy_quiet; o_busy |-> !o_sda_oe; endproperty
	a_busy_quiet: assert property (p_busy_quiet) else $error("drive while busy");
	property p_oe_scl; $changed(o_sda_oe) |-> !i_scl; endproperty
	a_oe_scl: assert property (p_oe_scl) else $error("data moved in clock high");
	property p_ack_hold; $rose(o_sda_oe) |-> o_sda_oe [*8]; endproperty
	a_ack_hold: assert property (p_ack_hold) else $error("drive too short");
	property p_sel; $rose(o_sda_oe) |-> sel_q; endproperty
	a_sel: assert property (p_sel) else $error("drive without start");
	property p_stop_rel; stp |=> !o_sda_oe [*8]; endproperty
	a_stop_rel: assert property (p_stop_rel) else $error("drive after stop");
	c_prog: cover property ($fell(o_busy));
	c_poll: cover property (sta && o_busy);
	c_ack: cover property ($rose(o_sda_oe) && sel_q);
endmodule
`default_nettype wire

/* dv/sea_i2c_master.sv */
// Two-wire bus master model for the EEPROM slave bench
`timescale 1ns/100ps
`default_nettype none
module sea_i2c_master (
	// Clock and slave drive
	input  wire logic i_core_clk,
	input  wire logic i_sda_oe,
	input  wire logic i_sda_out,
	// Bus wires
	output var  logic o_scl,
	output wire logic o_sda
);
	logic pl = 1'h0;
	initial o_scl = 1'h1;
	// Open-drain line with pull-up
	assign o_sda = pl ? 1'h0 : (i_sda_oe ? i_sda_out : 1'h1);
	task automatic w(input int n);
		repeat (n) @(negedge i_core_clk);
	endtask
	task automatic bt(input logic b, output logic r);
		w(4);
		pl = !b;
		w(4);
		o_scl = 1'h1;
		w(8);
		r = o_sda;
		o_scl = 1'h0;
	endtask
	task automatic st();
		w(4);
		pl = 1'h0;
		w(4);
		o_scl = 1'h1;
		w(8);
		pl = 1'h1;
		w(8);
		o_scl = 1'h0;
	endtask
	task automatic sp();
		w(4);
		pl = 1'h1;
		w(4);
		o_scl = 1'h1;
		w(8);
		pl = 1'h0;
		w(8);
	endtask
	// Eight bits MSB first, ninth clock at level m; a set when line was low
	task automatic xb(input logic [7:0] d, input logic m, output logic [7:0] r, output logic a);
		logic x;
		for (int i = 7; i >= 0; i--)
			bt(d[i], r[i]);
		bt(m, x);
		a = !x;
	endtask
endmodule
`default_nettype wire

/* dv/sea_eeprom_slave_bench.sv */
// Self-checking bench for the EEPROM slave
`timescale 1ns/100ps
`default_nettype none
`define SEA_CHK(a, e) begin comparisons++; if ((a) !== (e)) begin n_errors++; $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, e); end end
module sea_eeprom_slave_bench;
	localparam int WR = 300;
	logic i_core_clk;
	logic i_sys_rst;
	logic wp = 1'h0;
	logic vlow = 1'h0;
	logic [2:0] cs = 3'h5;
	wire  sdo;
	wire  scl;
	wire  sda;
	wire  oe;
	wire  busy;
	int   n_errors = 0;
	int   comparisons = 0;
	sea_eeprom_slave #(.LOCKOUT_EN(1), .WR_CYCLES(WR), .WR_CNT_W(24)) DUT (.i_core_clk(i_core_clk),
		.i_sys_rst(i_sys_rst), .i_ce(1'h1), .i_scl(scl), .i_sda(sda), .o_sda_out(sdo), .o_sda_oe(oe),
		.i_chip_select_pins(cs), .i_wp(wp), .i_vcc_low(vlow), .o_busy(busy));
	sea_i2c_master m (.i_core_clk(i_core_clk), .i_sda_oe(oe), .i_sda_out(sdo), .o_scl(scl), .o_sda(sda));
	task automatic print_verdict();
		$display("comparisons=%0d n_errors=%0d", comparisons, n_errors);
		if (n_errors == 0 && comparisons > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task automatic tx(input logic [7:0] d, input logic e);
		logic [7:0] r;
		logic       a;
		m.xb(d, 1'h1, r, a);
		`SEA_CHK(a, e)
	endtask
	task automatic rx(input logic [7:0] e, input logic nak);
		logic [7:0] r;
		logic       a;
		m.xb(8'hFF, nak, r, a);
		`SEA_CHK(r, e)
	endtask
	task automatic hdr(input logic [11:0] a, input logic [3:0] hi);
		m.st();
		tx(8'hAA, 1'h1);
		tx({hi, a[11:8]}, 1'h1);
		tx(a[7:0], 1'h1);
	endtask
	task automatic rd(input logic [11:0] a);
		hdr(a, 4'h0);
		m.st();
		tx(8'hAB, 1'h1);
	endtask
	task automatic ck_busy(input logic e);
		m.sp();
		repeat (8) @(negedge i_core_clk);
		`SEA_CHK(busy, e)
	endtask
	task automatic pw();
		ck_busy(1'h1);
		m.st();
		tx(8'hAA, 1'h0);
		m.sp();
		for (int i = 0; i < WR && busy; i++)
			@(negedge i_core_clk);
		m.st();
		tx(8'hAA, 1'h1);
		m.sp();
	endtask
	task automatic t_sel();
		m.st();
		tx(8'hA0, 1'h0);
		cs = 3'h0;
		m.st();
		tx(8'hA0, 1'h1);
		m.sp();
		cs = 3'h5;
		m.st();
		tx(8'hBA, 1'h0);
		m.sp();
		$display("t_sel done");
	endtask
	task automatic t_byte();
		hdr(12'h123, 4'h0);
		tx(8'h5A, 1'h1);
		tx(8'hA5, 1'h1);
		pw();
		rd(12'h123);
		rx(8'h5A, 1'h1);
		m.sp();
		m.st();
		tx(8'hAB, 1'h1);
		rx(8'hA5, 1'h1);
		m.sp();
		$display("t_byte done");
	endtask
	task automatic t_page();
		int k;
		hdr(12'h03C, 4'h0);
		for (int i = 0; i < 34; i++)
			tx(8'h40 + i[7:0], 1'h1);
		pw();
		rd(12'h020);
		for (int o = 0; o < 32; o++) begin
			k = (o + 4) % 32;
			rx(8'h40 + 8'(k < 2 ? k + 32 : k), o == 31);
		end
		m.sp();
		$display("t_page done");
	endtask
	task automatic t_wrap();
		hdr(12'hFFF, 4'hF);
		tx(8'hC3, 1'h1);
		pw();
		hdr(12'h000, 4'h0);
		tx(8'h3C, 1'h1);
		pw();
		rd(12'hFFF);
		rx(8'hC3, 1'h0);
		rx(8'h3C, 1'h1);
		m.sp();
		$display("t_wrap done");
	endtask
	task automatic t_prot();
		wp = 1'h1;
		hdr(12'hFFF, 4'h0);
		tx(8'h11, 1'h0);
		ck_busy(1'h0);
		hdr(12'h7FF, 4'h0);
		tx(8'h77, 1'h1);
		pw();
		rd(12'h7FF);
		rx(8'h77, 1'h1);
		m.sp();
		wp = 1'h0;
		rd(12'hFFF);
		rx(8'hC3, 1'h1);
		m.sp();
		vlow = 1'h1;
		hdr(12'h124, 4'h0);
		tx(8'h00, 1'h0);
		ck_busy(1'h0);
		vlow = 1'h0;
		rd(12'h124);
		rx(8'hA5, 1'h1);
		m.sp();
		$display("t_prot done");
	endtask
	initial begin
		i_core_clk = 1'h0;
		forever #5 i_core_clk = ~i_core_clk;
	end
	initial begin
		#600000;
		n_errors++;
		print_verdict();
	end
	initial begin
		i_sys_rst = 1'h1;
		repeat (4) @(negedge i_core_clk);
		i_sys_rst = 1'h0;
		repeat (8) @(negedge i_core_clk);
		`SEA_CHK(busy, 1'h0)
		t_sel();
		t_byte();
		t_page();
		t_wrap();
		t_prot();
		print_verdict();
	end
endmodule
bind sea_eeprom_slave sea_eeprom_slave_monitor #(.WR_CYCLES(WR_CYCLES)) u_mon (.i_core_clk(i_core_clk),
	.i_sys_rst(i_sys_rst), .i_scl(i_scl), .i_sda(i_sda), .o_sda_oe(o_sda_oe), .o_busy(o_busy));
`default_nettype wire
